// >>> hdl/sbt_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// Small valid/ready buffer; full and empty come from the entry count
module sbt_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Whole buffer state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sbt_buf_s;
    sbt_buf_s s_q;
    sbt_buf_s s_d;
    logic push;
    logic pop;

    // Handshakes from the count
    assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Next state: write, read, count
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + AW'(1);
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + AW'(1);
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : sbt_buf2
`default_nettype wire

// >>> hdl/sbt_tap.sv
// Contract
// - 3-bit instruction; 000 captures the ring
// - IDCODE loads and shifts the 32-bit identity
// - 010 captures, shifts chain, floats outputs
// - 100 captures ring, shifts 109-cell chain
// - 111 puts one bypass cell in path
// - Identity fields: revision, part, vendor, one
`timescale 1ns/1ps
`default_nettype none
module sbt_tap #(
    parameter logic [2:0] ID_REV = 3'h5,
    parameter logic [16:0] ID_PART = 17'h0abcd,
    parameter logic [10:0] ID_VEND = 11'h155
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire sbt_pkg::sbt_pins_s pins,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [sbt_pkg::BSR_LEN-1:0] ring_in,
    output logic float_outputs,
    output logic upd_room,
    output logic upd_valid,
    input wire logic upd_ready,
    output sbt_pkg::sbt_upd_s upd_data
);
    // Identity values above are arbitrary
    localparam logic [sbt_pkg::ID_LEN-1:0] ID_WORD = {ID_REV, ID_PART, ID_VEND,
        sbt_pkg::ID_PRESENT};

    // Whole block state
    typedef struct packed {
        logic [sbt_pkg::SYNC_LEN-1:0] tck_s;
        logic [sbt_pkg::SYNC_LEN-1:0] tms_s;
        logic [sbt_pkg::SYNC_LEN-1:0] tdi_s;
        logic tck_lvl;
        logic tms_lvl;
        logic tdi_lvl;
        sbt_pkg::sbt_tap_e tap;
        logic [sbt_pkg::IR_LEN-1:0] ir_sh;
        logic [sbt_pkg::IR_LEN-1:0] ir;
        logic byp;
        logic [sbt_pkg::ID_LEN-1:0] id;
        logic [sbt_pkg::BSR_LEN-1:0] bsr;
        logic tdo;
        logic tdo_oe;
        logic push;
        logic drive;
    } sbt_state_s;

    sbt_state_s s_q;
    sbt_state_s s_d;
    logic rise;
    logic fall;
    logic tck_ok;
    sbt_pkg::sbt_upd_s push_word;

    // Data register behind an instruction; reserved codes fall to bypass
    function automatic sbt_pkg::sbt_sel_e dr_sel(input logic [2:0] code);
        sbt_pkg::sbt_sel_e sel;
        sel = sbt_pkg::SEL_BYP;
        if (code == sbt_pkg::IR_IDCODE) begin
            sel = sbt_pkg::SEL_ID;
        end else if (code == sbt_pkg::IR_EXTEST || code == sbt_pkg::IR_FLOAT ||
                     code == sbt_pkg::IR_SAMPLE) begin
            sel = sbt_pkg::SEL_BSR;
        end
        return sel;
    endfunction : dr_sel

    // TAP state walk on TMS
    function automatic sbt_pkg::sbt_tap_e tap_next(input sbt_pkg::sbt_tap_e st,
                                                   input logic tms);
        sbt_pkg::sbt_tap_e nx;
        nx = st;
        unique case (st)
            sbt_pkg::TL_RESET: nx = tms ? sbt_pkg::TL_RESET : sbt_pkg::RUN_IDLE;
            sbt_pkg::RUN_IDLE: nx = tms ? sbt_pkg::SEL_DR : sbt_pkg::RUN_IDLE;
            sbt_pkg::SEL_DR: nx = tms ? sbt_pkg::SEL_IR : sbt_pkg::CAP_DR;
            sbt_pkg::CAP_DR: nx = tms ? sbt_pkg::EX1_DR : sbt_pkg::SH_DR;
            sbt_pkg::SH_DR: nx = tms ? sbt_pkg::EX1_DR : sbt_pkg::SH_DR;
            sbt_pkg::EX1_DR: nx = tms ? sbt_pkg::UPD_DR : sbt_pkg::PA_DR;
            sbt_pkg::PA_DR: nx = tms ? sbt_pkg::EX2_DR : sbt_pkg::PA_DR;
            sbt_pkg::EX2_DR: nx = tms ? sbt_pkg::UPD_DR : sbt_pkg::SH_DR;
            sbt_pkg::UPD_DR: nx = tms ? sbt_pkg::SEL_DR : sbt_pkg::RUN_IDLE;
            sbt_pkg::SEL_IR: nx = tms ? sbt_pkg::TL_RESET : sbt_pkg::CAP_IR;
            sbt_pkg::CAP_IR: nx = tms ? sbt_pkg::EX1_IR : sbt_pkg::SH_IR;
            sbt_pkg::SH_IR: nx = tms ? sbt_pkg::EX1_IR : sbt_pkg::SH_IR;
            sbt_pkg::EX1_IR: nx = tms ? sbt_pkg::UPD_IR : sbt_pkg::PA_IR;
            sbt_pkg::PA_IR: nx = tms ? sbt_pkg::EX2_IR : sbt_pkg::PA_IR;
            sbt_pkg::EX2_IR: nx = tms ? sbt_pkg::UPD_IR : sbt_pkg::SH_IR;
            sbt_pkg::UPD_IR: nx = tms ? sbt_pkg::SEL_DR : sbt_pkg::RUN_IDLE;
        endcase
        return nx;
    endfunction : tap_next

    // TCK edges count once the last two synchroniser stages agree
    assign tck_ok = (s_q.tck_s[1] == s_q.tck_s[2]);
    assign rise = tck_ok & s_q.tck_s[2] & ~s_q.tck_lvl;
    assign fall = tck_ok & ~s_q.tck_s[2] & s_q.tck_lvl;

    // Outputs straight from state
    assign tdo = s_q.tdo;
    assign tdo_oe = s_q.tdo_oe;
    assign float_outputs = (s_q.ir == sbt_pkg::IR_FLOAT);
    assign push_word.drive = s_q.drive;
    assign push_word.cells = s_q.bsr;

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        // Pin synchronisers; first stage only feeds the second
        s_d.tck_s = {s_q.tck_s[1:0], pins.tck};
        s_d.tms_s = {s_q.tms_s[1:0], pins.tms};
        s_d.tdi_s = {s_q.tdi_s[1:0], pins.tdi};
        if (tck_ok) begin
            s_d.tck_lvl = s_q.tck_s[2];
        end
        if (s_q.tms_s[1] == s_q.tms_s[2]) begin
            s_d.tms_lvl = s_q.tms_s[2];
        end
        if (s_q.tdi_s[1] == s_q.tdi_s[2]) begin
            s_d.tdi_lvl = s_q.tdi_s[2];
        end
        // Rising TCK: act on the current state, then move on
        if (rise) begin
            unique case (s_q.tap)
                sbt_pkg::TL_RESET: begin
                    s_d.ir = sbt_pkg::IR_RESET;
                end
                sbt_pkg::CAP_DR: begin
                    unique case (dr_sel(s_q.ir))
                        sbt_pkg::SEL_BYP: s_d.byp = sbt_pkg::BYP_CAPTURE;
                        sbt_pkg::SEL_ID: s_d.id = ID_WORD;
                        sbt_pkg::SEL_BSR: s_d.bsr = ring_in;
                    endcase
                end
                sbt_pkg::SH_DR: begin
                    unique case (dr_sel(s_q.ir))
                        sbt_pkg::SEL_BYP: s_d.byp = s_q.tdi_lvl;
                        sbt_pkg::SEL_ID: s_d.id = {s_q.tdi_lvl, s_q.id[31:1]};
                        sbt_pkg::SEL_BSR: begin
                            s_d.bsr = {s_q.tdi_lvl, s_q.bsr[sbt_pkg::BSR_LEN-1:1]};
                        end
                    endcase
                end
                sbt_pkg::UPD_DR: begin
                    // Preload and external test hand the chain to the ring
                    if (dr_sel(s_q.ir) == sbt_pkg::SEL_BSR && s_q.ir != sbt_pkg::IR_FLOAT) begin
                        s_d.push = 1'b1;
                        s_d.drive = (s_q.ir == sbt_pkg::IR_EXTEST);
                    end
                end
                sbt_pkg::CAP_IR: begin
                    s_d.ir_sh = sbt_pkg::IR_CAPTURE;
                end
                sbt_pkg::SH_IR: begin
                    s_d.ir_sh = {s_q.tdi_lvl, s_q.ir_sh[2:1]};
                end
                sbt_pkg::UPD_IR: begin
                    s_d.ir = s_q.ir_sh;
                end
                default: begin
                    // Other states hold the registers
                end
            endcase
            s_d.tap = tap_next(s_q.tap, s_q.tms_lvl);
        end
        // Falling TCK: present the next bit while shifting
        if (fall) begin
            s_d.tdo_oe = (s_q.tap == sbt_pkg::SH_DR) || (s_q.tap == sbt_pkg::SH_IR);
            if (s_q.tap == sbt_pkg::SH_IR) begin
                s_d.tdo = s_q.ir_sh[0];
            end else begin
                unique case (dr_sel(s_q.ir))
                    sbt_pkg::SEL_BYP: s_d.tdo = s_q.byp;
                    sbt_pkg::SEL_ID: s_d.tdo = s_q.id[0];
                    sbt_pkg::SEL_BSR: s_d.tdo = s_q.bsr[0];
                endcase
            end
        end
    end

    // State register; reset leaves the TAP in test-logic reset with IDCODE
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.ir <= sbt_pkg::IR_RESET;
            s_q.tap <= sbt_pkg::TL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Update words wait here until the ring takes them
    sbt_buf2 #(
        .WIDTH($bits(sbt_pkg::sbt_upd_s)),
        .DEPTH(sbt_pkg::UPD_DEPTH)
    ) u_upd_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(s_q.push),
        .in_ready(upd_room),
        .in_data(push_word),
        .out_valid(upd_valid),
        .out_ready(upd_ready),
        .out_data(upd_data)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Capture step for a given instruction
    sequence s_cap_dr(logic [2:0] code);
        rise && s_q.tap == sbt_pkg::CAP_DR && s_q.ir == code;
    endsequence

    chk_extest_capture: assert property (s_cap_dr(sbt_pkg::IR_EXTEST) |=>
        s_q.bsr == $past(ring_in)) else $error("extest did not capture ring");
    chk_ir_capture: assert property (rise && s_q.tap == sbt_pkg::CAP_IR |=>
        s_q.ir_sh == 3'h1) else $error("instruction capture pattern wrong");
    chk_id_capture: assert property (s_cap_dr(sbt_pkg::IR_IDCODE) |=>
        s_q.id == ID_WORD) else $error("identity word not loaded");
    chk_float_follow: assert property (rise && s_q.tap == sbt_pkg::UPD_IR |=>
        float_outputs == ($past(s_q.ir_sh) == 3'h2)) else $error("float flag wrong");
    chk_sample_capture: assert property (s_cap_dr(sbt_pkg::IR_SAMPLE) |=>
        s_q.bsr == $past(ring_in) && !float_outputs) else $error("sample capture wrong");
    chk_bypass_zero: assert property (s_cap_dr(sbt_pkg::IR_BYPASS) |=>
        s_q.byp == 1'b0) else $error("bypass cell not cleared");
    chk_id_present: assert property (s_cap_dr(sbt_pkg::IR_IDCODE) |=>
        s_q.id[0] == 1'b1 && s_q.id[31:29] == ID_REV) else $error("identity fields wrong");
    chk_reset_select: assert property (rise && s_q.tap == sbt_pkg::TL_RESET |=>
        s_q.ir == 3'h1 ##1 s_q.ir == 3'h1) else $error("reset did not pick identity");
    chk_tdo_enable: assert property (fall && s_q.tap == sbt_pkg::SH_DR |=>
        tdo_oe ##1 tdo_oe) else $error("tdo not enabled in shift");
    chk_push_pulse: assert property (s_q.push |=> !s_q.push)
        else $error("update push longer than one cycle");
endmodule : sbt_tap
`default_nettype wire

// >>> pkg/sbt_pkg.sv
`default_nettype none
package sbt_pkg;
    // Scan register lengths
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN = 109;
    // Depth of each pin synchroniser
    localparam int SYNC_LEN = 3;
    // Depth of the update word buffer
    localparam int UPD_DEPTH = 2;
    // Instruction codes
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_FLOAT = 3'h2;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    // Fixed pattern loaded into the instruction shifter at capture
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    // Instruction selected after a TAP reset
    localparam logic [2:0] IR_RESET = IR_IDCODE;
    // Identification word field positions
    localparam int ID_REV_LSB = 29;
    localparam int ID_PART_LSB = 12;
    localparam int ID_VEND_LSB = 1;
    // Presence bit of the identification word
    localparam logic ID_PRESENT = 1'b1;
    // Value captured into the bypass cell
    localparam logic BYP_CAPTURE = 1'b0;
    // Data register selected by an instruction
    typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_BSR} sbt_sel_e;
    // TAP controller states
    typedef enum logic [3:0] {
        TL_RESET, RUN_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } sbt_tap_e;
    // Test pins from the controller
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbt_pins_s;
    // Word handed to the pin ring at update
    typedef struct packed {
        logic drive;
        logic [BSR_LEN-1:0] cells;
    } sbt_upd_s;
endpackage : sbt_pkg
`default_nettype wire

// >>> verif/sbt_jtag_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural test controller; TCK rests low between frames
module sbt_jtag_model (
    input wire logic clk_sys,
    input wire logic tdo,
    output sbt_pkg::sbt_pins_s pins
);
    // Sink for bits that nobody reads
    logic unused_bit;

    // Pins idle low from time zero
    initial begin
        pins = '0;
    end

    // One TCK period of 16 clk: set TMS/TDI while low, sample tdo just before the rise
    task automatic step(input logic tms, input logic tdi, output logic bit_out);
        pins.tms = tms;
        pins.tdi = tdi;
        repeat (8) @(posedge clk_sys);
        #1;
        bit_out = tdo;
        pins.tck = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        pins.tck = 1'b0;
    endtask : step

    // Five rises with TMS high, then one low lands in Run-Idle
    task automatic tap_reset();
        repeat (5) step(1'b1, ~pins.tdi, unused_bit);
        step(1'b0, ~pins.tdi, unused_bit);
    endtask : tap_reset

    // Scan n bits LSB first through IR or DR, Run-Idle back to Run-Idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        dout = '0;
        step(1'b1, ~pins.tdi, unused_bit);
        if (ir) begin
            step(1'b1, ~pins.tdi, unused_bit);
        end
        // Capture, then into Shift; idle TDI keeps toggling
        step(1'b0, ~pins.tdi, unused_bit);
        step(1'b0, ~pins.tdi, unused_bit);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        // Update, then Run-Idle
        step(1'b1, ~pins.tdi, unused_bit);
        step(1'b0, ~pins.tdi, unused_bit);
    endtask : scan
endmodule : sbt_jtag_model
`default_nettype wire

// >>> verif/sbt_tap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_tb;
    // Identity fields: arbitrary values
    localparam logic [2:0] REV = 3'h6;
    localparam logic [16:0] PART = 17'h12345;
    localparam logic [10:0] VEND = 11'h2a3;
    localparam logic [31:0] ID_EXP = {REV, PART, VEND, 1'b1};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic upd_ready = 1'b0;
    logic [sbt_pkg::BSR_LEN-1:0] ring_in = '0;
    sbt_pkg::sbt_pins_s pins;
    sbt_pkg::sbt_upd_s upd_data;
    logic tdo, tdo_oe, float_outputs, upd_room, upd_valid;
    logic [31:0] seed = 32'h0342cbaa;
    logic [127:0] din, dout, w0, w1;
    logic [2:0] codes [3] = '{sbt_pkg::IR_EXTEST, sbt_pkg::IR_SAMPLE, sbt_pkg::IR_FLOAT};
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    sbt_tap #(.ID_REV(REV), .ID_PART(PART), .ID_VEND(VEND)) i_sbt_tap (
        .clk_sys(clk_sys), .reset_n(reset_n), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe),
        .ring_in(ring_in), .float_outputs(float_outputs), .upd_room(upd_room),
        .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_data(upd_data));
    sbt_jtag_model i_sbt_jtag_model (.clk_sys(clk_sys), .tdo(tdo), .pins(pins));

    // Galois LFSR step
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr
    // Four random words packed wide
    task automatic rnd(output logic [127:0] v);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v[i*32 +: 32] = seed;
        end
    endtask : rnd
    // Count and report one comparison
    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Load an instruction; the shifted-out bits are the capture pattern
    task automatic load_ir(input logic [2:0] code);
        i_sbt_jtag_model.scan(1'b1, 3, {125'h0, code}, dout);
        check("ir capture", {125'h0, 3'h1}, {125'h0, dout[2:0]});
    endtask : load_ir
    // Wait for a buffered word, compare, then pop with a one-cycle ready
    task automatic pop(input logic [109:0] exp);
        int n = 0;
        while (upd_valid !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check("upd_valid", 128'h1, {127'h0, upd_valid});
        check("upd_data", {18'h0, exp}, {18'h0, upd_data});
        @(posedge clk_sys) #1 upd_ready = 1'b1;
        @(posedge clk_sys) #1 upd_ready = 1'b0;
    endtask : pop
    // Counts, verdict, stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Hang guard: about twice the expected run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        // Identity selected out of reset, pin outputs not floated, TDO off
        i_sbt_jtag_model.tap_reset();
        i_sbt_jtag_model.scan(1'b0, 32, 128'h0, dout);
        check("idcode", {96'h0, ID_EXP}, dout);
        check("float idle", 128'h0, {127'h0, float_outputs});
        check("oe idle", 128'h0, {127'h0, tdo_oe});
        $display("test idcode done");
        // Bypass delays TDI by one cell, captured zero first
        load_ir(sbt_pkg::IR_BYPASS);
        rnd(din);
        i_sbt_jtag_model.scan(1'b0, 16, din, dout);
        check("bypass", {112'h0, din[14:0], 1'b0}, {112'h0, dout[15:0]});
        $display("test bypass done");
        // Each chain instruction: capture ring, shift 109 cells, update rules
        for (int k = 0; k < 3; k++) begin
            load_ir(codes[k]);
            check("float", {127'h0, codes[k] == sbt_pkg::IR_FLOAT}, {127'h0, float_outputs});
            rnd(din);
            ring_in = din[108:0];
            rnd(din);
            i_sbt_jtag_model.scan(1'b0, 109, din, dout);
            check("ring", {19'h0, ring_in}, {19'h0, dout[108:0]});
            if (codes[k] != sbt_pkg::IR_FLOAT) pop({codes[k] == sbt_pkg::IR_EXTEST, din[108:0]});
            else check("no push", 128'h0, {127'h0, upd_valid});
        end
        $display("test chain codes done");
        // Stalled ring: two words held, third dropped, order kept
        load_ir(sbt_pkg::IR_SAMPLE);
        rnd(w0);
        i_sbt_jtag_model.scan(1'b0, 109, w0, dout);
        rnd(w1);
        i_sbt_jtag_model.scan(1'b0, 109, w1, dout);
        check("room full", 128'h0, {127'h0, upd_room});
        rnd(din);
        i_sbt_jtag_model.scan(1'b0, 109, din, dout);
        pop({1'b0, w0[108:0]});
        pop({1'b0, w1[108:0]});
        repeat (3) @(posedge clk_sys);
        #1 check("drained", 128'h1, {126'h0, upd_valid, upd_room});
        $display("test buffer done");
        // TMS reset brings identity back
        i_sbt_jtag_model.tap_reset();
        i_sbt_jtag_model.scan(1'b0, 32, 128'h0, dout);
        check("idcode again", {96'h0, ID_EXP}, dout);
        $display("test tap reset done");
        end_sim();
    end
endmodule : sbt_tap_tb
`default_nettype wire
